// file: verilog/sbz_pkg.sv
// package: encodings, formats, ops and states of the simd bit-set/compare/branch slice
package sbz_pkg;

   // ******************************************************************
   // instruction fields
   // ******************************************************************
   localparam int MAJOR_HI        = 31;
   localparam int MAJOR_LO        = 26;
   localparam int MINOR_HI        = 5;
   localparam int MINOR_LO        = 0;
   localparam int OPSEL_HI        = 25;
   localparam int OPSEL_LO        = 23;
   localparam int FMT_HI          = 22;
   localparam int FMT_LO          = 21;
   localparam int FMTPOS_HI       = 22;
   localparam int FMTPOS_LO       = 16;
   localparam int SHORT_LIT_HI    = 20;
   localparam int SHORT_LIT_LO    = 16;
   localparam int DEST_HI         = 10;
   localparam int DEST_LO         = 6;
   localparam int BR_SEL_HI       = 25;
   localparam int BR_SEL_LO       = 21;
   localparam int BR_OFFSET_HI    = 15;
   localparam int BR_OFFSET_LO    = 0;
   localparam int BR_OFFSET_WIDTH = 16;
   localparam int WORD_SHIFT      = 2;   // offset counts 32-bit words

   // ******************************************************************
   // encodings
   // ******************************************************************
   localparam logic [5:0] MAJOR_SIMD      = 6'h1e;
   localparam logic [5:0] MINOR_BIT_LIT   = 6'h09;
   localparam logic [2:0] OPSEL_BIT_SET   = 3'h4;
   localparam logic [5:0] MINOR_3R_SET    = 6'h0d;
   localparam logic [5:0] MINOR_3R_CMP    = 6'h0f;
   localparam logic [5:0] MINOR_LIT5      = 6'h07;
   localparam logic [2:0] OPSEL_CMP_EQ    = 3'h0;
   localparam logic [5:0] MAJOR_BRANCH    = 6'h11;
   localparam logic [2:0] BR_ANY_SEL      = 3'h6;
   localparam logic [4:0] BR_VEC_SEL      = 5'h0b;

   // element formats
   localparam logic [1:0] FMT_BYTE        = 2'h0;
   localparam logic [1:0] FMT_HALF        = 2'h1;
   localparam logic [1:0] FMT_WORD        = 2'h2;
   localparam logic [1:0] FMT_DOUBLE      = 2'h3;
   localparam int         NUM_FMT         = 4;
   localparam int         BYTE_BITS       = 8;

   // ******************************************************************
   // sizes and reset values
   // ******************************************************************
   localparam int          VECTOR_WIDTH_BITS      = 128;
   localparam int          GENERAL_REGISTER_WIDTH = 64;
   localparam logic [4:0]  DEST_RESET             = 5'h00;
   localparam logic [15:0] OFFSET_RESET           = 16'h0000;

   typedef enum logic [1:0] {
      OP_BSET_REG = 2'h0,
      OP_BSET_LIT = 2'h1,
      OP_CEQ_REG  = 2'h2,
      OP_CEQ_LIT  = 2'h3
   } sbz_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SLOT = 2'b10
   } sbz_state_t;

endpackage

// file: verilog/sbz_elem_lane.sv
// one element lane: bit set and compare-equal at a fixed element width
`timescale 1ns/10ps
`default_nettype none
module sbz_elem_lane #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0]     first_in,     // source element
   input  wire logic [WIDTH-1:0]     second_in,    // second/tested element
   input  wire logic [5:0]           lit_index_in, // literal bit index
   input  wire logic [4:0]           short_lit_in, // 5-bit signed literal
   input  wire sbz_pkg::sbz_op_t     op_in,        // operation
   output logic      [WIDTH-1:0]     result_out,   // element result
   output logic                      zero_out      // tested element is zero
);
   localparam int IDXW = $clog2(WIDTH);

   wire [WIDTH-1:0] one_hot_base = {{(WIDTH-1){1'b0}}, 1'b1};
   // index modulo element width is just its low bits
   wire [IDXW-1:0]  reg_index    = second_in[IDXW-1:0];
   wire [IDXW-1:0]  lit_index    = lit_index_in[IDXW-1:0];
   wire [WIDTH-1:0] reg_mask     = one_hot_base << reg_index;
   wire [WIDTH-1:0] lit_mask     = one_hot_base << lit_index;
   wire [WIDTH-1:0] lit_extended = {{(WIDTH-5){short_lit_in[4]}},
                                    short_lit_in};
   wire             equal_reg    = (first_in == second_in);
   wire             equal_lit    = (first_in == lit_extended);

   assign result_out =
      (op_in == sbz_pkg::OP_BSET_REG) ? (first_in | reg_mask) :  // RULE1
      (op_in == sbz_pkg::OP_BSET_LIT) ? (first_in | lit_mask) :  // RULE3
      (op_in == sbz_pkg::OP_CEQ_REG)  ? {WIDTH{equal_reg}} :     // RULE12
                                        {WIDTH{equal_lit}};      // RULE13
   assign zero_out = ~|second_in;
endmodule
`default_nettype wire

// file: verilog/sbz_simd_slice.sv
// simd execution slice: bit set, compare equal and zero-test branches
//
// How it works
// RULE1 - register bit set ors a one-hot mask into each source element
// RULE2 - register bit index comes from second source element modulo width
// RULE3 - literal bit set uses the encoded index for every element
// RULE4 - elements are bytes, halfwords, words or doublewords over the vector
// RULE5 - bit set and compare equal never raise data-dependent exceptions
// RULE6 - literal bit set decodes from major 011110, minor 001001
// RULE7 - any-element branch taken when some element at format equals zero
// RULE8 - whole-vector branch taken only when every bit is zero
// RULE9 - the instruction after a taken branch runs before the redirect
// RULE10 - target is delay-slot pc plus signed word offset times four
// RULE11 - source must not put a branch in a delay slot
// RULE12 - register compare writes all ones on equal elements, else zeros
// RULE13 - literal compare sign-extends 5-bit literal to element width
// RULE14 - exceptions are reserved-instruction or unit-disabled only
// RULE15 - seven-bit format/position field yields format and bit index
`timescale 1ns/10ps
`default_nettype none
module sbz_simd_slice #(
   parameter int VECTOR_WIDTH_BITS      = sbz_pkg::VECTOR_WIDTH_BITS,
   parameter int GENERAL_REGISTER_WIDTH = sbz_pkg::GENERAL_REGISTER_WIDTH
) (
   input  wire logic                              ref_clk_in,  // core clock
   input  wire logic                              rst_n_in,    // async reset
   input  wire logic                              instr_valid_in, // issue
   input  wire logic [31:0]                       instr_word_in,  // opcode
   input  wire logic [GENERAL_REGISTER_WIDTH-1:0] instr_pc_in,    // its pc
   input  wire logic                              unit_enable_in, // simd on
   input  wire logic [VECTOR_WIDTH_BITS-1:0]      first_source_vector_in,
                                                  // first source operand
   input  wire logic [VECTOR_WIDTH_BITS-1:0]      second_source_vector_in,
                                                  // second/tested operand
   output logic      [VECTOR_WIDTH_BITS-1:0]      dest_vector_out, // result
   output logic      [4:0]                        dest_index_out,  // target
   output logic                                   dest_write_out,  // write
   output logic                                   redirect_out,    // pc jump
   output logic      [GENERAL_REGISTER_WIDTH-1:0] redirect_target_out,
                                                  // new pc
   output logic                                   slot_pending_out, // wait
   output logic                                   exc_reserved_out, // ri
   output logic                                   exc_disabled_out  // off
);

   // ******************************************************************
   // decode
   // ******************************************************************
   wire [5:0] major    = instr_word_in[sbz_pkg::MAJOR_HI:sbz_pkg::MAJOR_LO];
   wire [5:0] minor    = instr_word_in[sbz_pkg::MINOR_HI:sbz_pkg::MINOR_LO];
   wire [2:0] opsel    = instr_word_in[sbz_pkg::OPSEL_HI:sbz_pkg::OPSEL_LO];
   wire [1:0] fmt_3r   = instr_word_in[sbz_pkg::FMT_HI:sbz_pkg::FMT_LO];
   wire [6:0] fmt_pos  =
      instr_word_in[sbz_pkg::FMTPOS_HI:sbz_pkg::FMTPOS_LO];
   wire [4:0] short_lit =
      instr_word_in[sbz_pkg::SHORT_LIT_HI:sbz_pkg::SHORT_LIT_LO];
   wire [4:0] dest_sel = instr_word_in[sbz_pkg::DEST_HI:sbz_pkg::DEST_LO];
   wire [4:0] br_sel   =
      instr_word_in[sbz_pkg::BR_SEL_HI:sbz_pkg::BR_SEL_LO];
   wire [15:0] br_offset =
      instr_word_in[sbz_pkg::BR_OFFSET_HI:sbz_pkg::BR_OFFSET_LO];

   wire is_simd_major = (major == sbz_pkg::MAJOR_SIMD);
   wire is_br_major   = (major == sbz_pkg::MAJOR_BRANCH);

   wire is_bset_reg = is_simd_major && (minor == sbz_pkg::MINOR_3R_SET)
                      && (opsel == sbz_pkg::OPSEL_BIT_SET);          // RULE1
   wire is_bset_lit = is_simd_major && (minor == sbz_pkg::MINOR_BIT_LIT)
                      && (opsel == sbz_pkg::OPSEL_BIT_SET);          // RULE6
   wire is_ceq_reg  = is_simd_major && (minor == sbz_pkg::MINOR_3R_CMP)
                      && (opsel == sbz_pkg::OPSEL_CMP_EQ);           // RULE12
   wire is_ceq_lit  = is_simd_major && (minor == sbz_pkg::MINOR_LIT5)
                      && (opsel == sbz_pkg::OPSEL_CMP_EQ);           // RULE13
   wire is_br_any   = is_br_major
                      && (br_sel[4:2] == sbz_pkg::BR_ANY_SEL);       // RULE7
   wire is_br_vec   = is_br_major && (br_sel == sbz_pkg::BR_VEC_SEL); // RULE8

   wire is_vector_op = is_bset_reg || is_bset_lit || is_ceq_reg
                       || is_ceq_lit;
   wire is_branch    = is_br_any || is_br_vec;
   wire is_ours      = is_vector_op || is_branch;

   // format/position field: 0mmmmmm double, 10mmmmm word,
   // 110mmmm half, 1110mmm byte, 1111xxx has no meaning
   wire       fp_double = ~fmt_pos[6];
   wire       fp_word   = (fmt_pos[6:5] == 2'b10);
   wire       fp_half   = (fmt_pos[6:4] == 3'b110);
   wire       fp_byte   = (fmt_pos[6:3] == 4'b1110);
   wire       fp_bad    = (fmt_pos[6:3] == 4'b1111);                // RULE15
   wire [1:0] fp_format = fp_double ? sbz_pkg::FMT_DOUBLE :
                          fp_word   ? sbz_pkg::FMT_WORD :
                          fp_half   ? sbz_pkg::FMT_HALF :
                                      sbz_pkg::FMT_BYTE;             // RULE15
   wire [5:0] fp_index  = fp_double ? fmt_pos[5:0] :
                          fp_word   ? {1'b0, fmt_pos[4:0]} :
                          fp_half   ? {2'b00, fmt_pos[3:0]} :
                                      {3'b000, fmt_pos[2:0]};        // RULE15

   wire [1:0] active_fmt = is_bset_lit ? fp_format : fmt_3r;         // RULE4

   sbz_pkg::sbz_op_t lane_op;
   assign lane_op = is_bset_reg ? sbz_pkg::OP_BSET_REG :
                    is_bset_lit ? sbz_pkg::OP_BSET_LIT :
                    is_ceq_reg  ? sbz_pkg::OP_CEQ_REG :
                                  sbz_pkg::OP_CEQ_LIT;

   // ******************************************************************
   // element lanes, one set per format
   // ******************************************************************
   wire [VECTOR_WIDTH_BITS-1:0] fmt_result [0:sbz_pkg::NUM_FMT-1];
   wire [sbz_pkg::NUM_FMT-1:0]  fmt_any_zero;

   // all four formats are computed every cycle and the decoded one is
   // picked; costs area but keeps the result path one mux deep
   genvar f;
   genvar e;
   generate
      for (f = 0; f < sbz_pkg::NUM_FMT; f = f + 1) begin : g_fmt
         localparam int ELEM_W = sbz_pkg::BYTE_BITS << f;
         localparam int ELEM_N = VECTOR_WIDTH_BITS / ELEM_W;
         wire [ELEM_N-1:0] elem_zero;
         for (e = 0; e < ELEM_N; e = e + 1) begin : g_elem
            sbz_elem_lane #(
               .WIDTH        (ELEM_W)
            ) u_lane (
               .first_in     (first_source_vector_in[e*ELEM_W +: ELEM_W]),
               .second_in    (second_source_vector_in[e*ELEM_W +: ELEM_W]),
               .lit_index_in (fp_index),
               .short_lit_in (short_lit),
               .op_in        (lane_op),
               .result_out   (fmt_result[f][e*ELEM_W +: ELEM_W]),
               .zero_out     (elem_zero[e])
            );                                                       // RULE2
         end
         assign fmt_any_zero[f] = |elem_zero;                        // RULE7
      end
   endgenerate

   wire [VECTOR_WIDTH_BITS-1:0] picked_result = fmt_result[active_fmt];
   wire any_elem_zero = fmt_any_zero[fmt_3r];                        // RULE7
   wire whole_zero    = ~|second_source_vector_in;                   // RULE8
   wire branch_cond   = is_br_any ? any_elem_zero : whole_zero;

   // ******************************************************************
   // exceptions
   // ******************************************************************
   // only two kinds exist; operand values never raise anything here
   wire raise_disabled = instr_valid_in && is_ours
                         && !unit_enable_in;                         // RULE14
   wire raise_reserved = instr_valid_in && is_bset_lit && fp_bad
                         && unit_enable_in;                          // RULE14
   wire raise_any      = raise_disabled || raise_reserved;
   wire do_vector      = instr_valid_in && is_vector_op
                         && !raise_any;                              // RULE5

   // ******************************************************************
   // branch sequencing with delay slot
   // ******************************************************************
   sbz_pkg::sbz_state_t state;
   sbz_pkg::sbz_state_t next_state;
   logic [15:0]         held_offset;
   logic [15:0]         next_held_offset;
   logic                next_redirect;

   wire [GENERAL_REGISTER_WIDTH-1:0] offset_bytes =
      {{(GENERAL_REGISTER_WIDTH-sbz_pkg::BR_OFFSET_WIDTH
         -sbz_pkg::WORD_SHIFT){held_offset[15]}},
       held_offset, {sbz_pkg::WORD_SHIFT{1'b0}}};                    // RULE10
   // the pc seen in the slot state belongs to the delay-slot instruction
   wire [GENERAL_REGISTER_WIDTH-1:0] slot_target =
      instr_pc_in + offset_bytes;                                    // RULE10

   always_comb begin
      next_state       = state;
      next_held_offset = held_offset;
      next_redirect    = 1'b0;
      case (state)
         sbz_pkg::ST_IDLE: begin
            if (instr_valid_in && is_branch && !raise_any
                && branch_cond) begin
               next_state       = sbz_pkg::ST_SLOT;                 // RULE9
               next_held_offset = br_offset;
            end
         end
         sbz_pkg::ST_SLOT: begin
            // any issued instruction is the delay slot; a branch there is
            // not evaluated, so the first branch's target wins
            if (instr_valid_in) begin
               next_state    = sbz_pkg::ST_IDLE;                     // RULE11
               next_redirect = !raise_any;                           // RULE9
            end
         end
         default: begin
            next_state = sbz_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state       <= sbz_pkg::ST_IDLE;
         held_offset <= sbz_pkg::OFFSET_RESET;
      end else begin
         state       <= next_state;
         held_offset <= next_held_offset;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         redirect_out        <= 1'b0;
         redirect_target_out <= '0;
      end else begin
         redirect_out <= next_redirect;
         if (next_redirect) begin
            redirect_target_out <= slot_target;                      // RULE10
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         slot_pending_out <= 1'b0;
      end else begin
         slot_pending_out <= (next_state == sbz_pkg::ST_SLOT);
      end
   end

   // ******************************************************************
   // result and exception outputs
   // ******************************************************************
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dest_write_out  <= 1'b0;
         dest_index_out  <= sbz_pkg::DEST_RESET;
         dest_vector_out <= '0;
      end else begin
         dest_write_out <= do_vector;
         if (do_vector) begin
            dest_index_out  <= dest_sel;
            dest_vector_out <= picked_result;                        // RULE4
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         exc_reserved_out <= 1'b0;
         exc_disabled_out <= 1'b0;
      end else begin
         exc_reserved_out <= raise_reserved;                         // RULE14
         exc_disabled_out <= raise_disabled;                         // RULE14
      end
   end

endmodule
`default_nettype wire

// file: verification/sbz_simd_monitor.sv
// checker: port-level assertions for the simd execution slice
`timescale 1ns/10ps
`default_nettype none
module sbz_simd_monitor #(
   parameter int VW = 128, // vector width in bits
   parameter int GW = 64   // general register width
) (
   input wire logic          ref_clk_in, // clock
   input wire logic          rst_n_in, // reset
   input wire logic          instr_valid_in, // issue
   input wire logic [31:0]   instr_word_in, // opcode
   input wire logic [GW-1:0] instr_pc_in, // pc
   input wire logic          unit_enable_in, // unit on
   input wire logic [VW-1:0] first_source_vector_in, // source
   input wire logic [VW-1:0] second_source_vector_in, // tested
   input wire logic [VW-1:0] dest_vector_out, // result
   input wire logic [4:0]    dest_index_out, // target
   input wire logic          dest_write_out, // write
   input wire logic          redirect_out, // jump
   input wire logic [GW-1:0] redirect_target_out, // new pc
   input wire logic          slot_pending_out, // wait
   input wire logic          exc_reserved_out, // ri
   input wire logic          exc_disabled_out  // off
);
   // ********************************************
   // decode of the issued word
   // ********************************************
   wire [5:0] minor  = instr_word_in[5:0];
   wire [2:0] opsel  = instr_word_in[25:23];
   wire is_simd = instr_valid_in && instr_word_in[31:26] == 6'h1e;
   wire is_bsetl = is_simd && opsel == 3'h4 && minor == 6'h09;
   wire is_ceq = is_simd && opsel == 3'h0 && minor == 6'h0f;
   wire is_vop = is_ceq || (is_simd && opsel == 3'h0 && minor == 6'h07)
                 || (is_simd && opsel == 3'h4 && minor == 6'h0d);
   wire is_brm = instr_valid_in && instr_word_in[31:26] == 6'h11;
   wire is_vbr = is_brm && instr_word_in[25:21] == 5'h0b;
   // offset of the last branch issued outside a slot
   logic [15:0] saved_off;
   wire [GW-1:0] off_bytes = {{(GW-18){saved_off[15]}}, saved_off, 2'h0};
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         saved_off <= 16'h0000;
      else if (is_brm && !slot_pending_out)
         saved_off <= instr_word_in[15:0];
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_slot_op;
      slot_pending_out && is_vop && unit_enable_in;
   endsequence
   sequence s_redirect;
      redirect_out && !slot_pending_out;
   endsequence
   a_slot_redirect: assert property (s_slot_op |=> s_redirect)
      else $error("no redirect after slot");
   a_redirect_cause: assert property (redirect_out |->
      $past(slot_pending_out && instr_valid_in)) else $error("stray redirect");
   a_slot_waits: assert property (slot_pending_out && !instr_valid_in
      |=> slot_pending_out && !redirect_out) else $error("slot wait broken");
   a_target_calc: assert property (redirect_out |->
      redirect_target_out == $past(instr_pc_in) + off_bytes)
      else $error("bad target");
   a_vec_zero: assert property (is_vbr && unit_enable_in && !slot_pending_out
      |=> slot_pending_out == ($past(second_source_vector_in) == '0))
      else $error("bad vector-zero decision");
   a_ceq_writes: assert property (is_ceq && unit_enable_in |=>
      dest_write_out && !exc_reserved_out && !exc_disabled_out)
      else $error("compare not written");
   a_write_cause: assert property (dest_write_out |->
      $past(is_simd && unit_enable_in)) else $error("write without cause");
   a_off_refused: assert property ((is_vop || is_bsetl || is_vbr)
      && !unit_enable_in |=> !dest_write_out && exc_disabled_out)
      else $error("disabled op acted");
   a_reserved_field: assert property (is_bsetl && unit_enable_in
      && instr_word_in[22:19] == 4'hf |=> exc_reserved_out && !dest_write_out)
      else $error("reserved field taken");
endmodule
bind sbz_simd_slice sbz_simd_monitor #(
   .VW(VECTOR_WIDTH_BITS),
   .GW(GENERAL_REGISTER_WIDTH)
) u_mon (.*);
`default_nettype wire

// file: verification/sbz_core_model.sv
// core-side model: issue stage that feeds the simd slice
`timescale 1ns/10ps
`default_nettype none
module sbz_core_model (
   input  wire logic    clk_in,      // core clock
   output logic         valid_out,   // issue strobe
   output logic [31:0]  word_out,    // instruction word
   output logic [63:0]  pc_out,      // its pc
   output logic         enable_out,  // simd unit on
   output logic [127:0] first_out,   // first source
   output logic [127:0] second_out   // second source
);
   initial begin
      valid_out = 1'b0;
      word_out = 32'h0000_0000;
      pc_out = 64'h0;
      enable_out = 1'b1;
      first_out = 128'h0;
      second_out = 128'h0;
   end
   // never puts a branch in a delay slot
   task automatic issue(input logic [31:0] w, input logic [63:0] pc,
                        input logic en, input logic [127:0] a,
                        input logic [127:0] b);
      @(posedge clk_in);
      valid_out <= 1'b1;
      word_out <= w;
      pc_out <= pc;
      enable_out <= en;
      first_out <= a;
      second_out <= b;
   endtask
   // idle cycles scramble the operands so stale data is never trusted
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk_in);
         valid_out <= 1'b0;
         first_out <= ~first_out;
         second_out <= ~second_out;
      end
   endtask
endmodule
`default_nettype wire

// file: verification/sbz_simd_slice_tb.sv
// testbench: self-checking run of the simd bit-set/compare/branch slice
`timescale 1ns/10ps
`default_nettype none
module sbz_simd_slice_tb;
   typedef struct {int kind; logic [127:0] vec; logic [4:0] idx;
      logic [63:0] tgt;} sbz_note_t;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   wire logic valid, en;
   wire logic [31:0] word;
   wire logic [63:0] pc;
   wire logic [127:0] src_a, src_b;
   logic [127:0] dest_vector, a, b;
   logic [63:0] target;
   logic [4:0] dest_index, s5, wd;
   logic write, redirect, pending, exc_res, exc_dis;
   logic [6:0] fld;
   logic [15:0] off;
   int w, lit, errors = 0, n_checks = 0, seed = 12462;
   sbz_note_t notes[$];
   sbz_core_model core (.clk_in(ref_clk_in), .valid_out(valid),
      .word_out(word), .pc_out(pc), .enable_out(en), .first_out(src_a),
      .second_out(src_b));
   sbz_simd_slice DUT (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .instr_valid_in(valid), .instr_word_in(word), .instr_pc_in(pc),
      .unit_enable_in(en), .first_source_vector_in(src_a),
      .second_source_vector_in(src_b), .dest_vector_out(dest_vector),
      .dest_index_out(dest_index), .dest_write_out(write),
      .redirect_out(redirect), .redirect_target_out(target),
      .slot_pending_out(pending), .exc_reserved_out(exc_res),
      .exc_disabled_out(exc_dis));
   always #12.5 ref_clk_in = ~ref_clk_in;
   // ********************************************
   // reference model and checking
   // ********************************************
   function automatic logic [127:0] fill(int w, logic [63:0] v);
      logic [127:0] r = '0;
      for (int e = 0; e < 128 / w; e++) r = r | (128'(v) << (e * w));
      return r;
   endfunction
   function automatic logic [127:0] model(int op, int w, logic [127:0] a,
      logic [127:0] b, int lit, logic [4:0] s5);
      logic [63:0] m, ea, eb, r;
      logic [127:0] res = '0;
      m = (w == 64) ? 64'hffff_ffff_ffff_ffff : (64'h1 << w) - 64'h1;
      for (int e = 0; e < 128 / w; e++) begin
         ea = 64'(a >> (e * w)) & m;
         eb = 64'(b >> (e * w)) & m;
         case (op)
            0: r = ea | (64'h1 << (eb & 64'(w - 1)));
            1: r = ea | (64'h1 << lit);
            2: r = (ea == eb) ? m : 64'h0;
            default: r = (ea == ({{59{s5[4]}}, s5} & m)) ? m : 64'h0;
         endcase
         res = res | (128'(r) << (e * w));
      end
      return res;
   endfunction
   function automatic logic [31:0] enc(int op, logic [1:0] f,
      logic [6:0] fld, logic [4:0] wd);
      case (op)
         0: return {6'h1e, 3'h4, f, 5'h02, 5'h01, wd, 6'h0d};
         1: return {6'h1e, 3'h4, fld, 5'h01, wd, 6'h09};
         2: return {6'h1e, 3'h0, f, 5'h02, 5'h01, wd, 6'h0f};
         default: return {6'h1e, 3'h0, f, fld[4:0], 5'h01, wd, 6'h07};
      endcase
   endfunction
   task automatic bad(string m);
      errors++;
      $display("BAD %0t %s", $time, m);
   endtask
   task automatic cmp_kind(int g, int e);
      n_checks++;
      if (g != e) bad("wrong kind");
   endtask
   task automatic cmp_vec(logic [132:0] g, logic [132:0] e);
      n_checks++;
      if (g !== e) bad("wrong vector");
   endtask
   task automatic cmp_tgt(logic [63:0] g, logic [63:0] e);
      n_checks++;
      if (g !== e) bad("wrong target");
   endtask
   task automatic expect_note(int k, logic [127:0] v, logic [4:0] i,
      logic [63:0] t);
      notes.push_back('{k, v, i, t});
   endtask
   task automatic take(int k, logic [132:0] v, logic [63:0] t);
      sbz_note_t n;
      if (notes.size() == 0) begin
         bad("unexpected result");
         return;
      end
      n = notes.pop_front();
      cmp_kind(k, n.kind);
      if (k == 0) cmp_vec(v, {n.idx, n.vec});
      if (k == 1) cmp_tgt(t, n.tgt);
   endtask
   always @(negedge ref_clk_in) begin
      if (rst_n_in && write === 1'b1) take(0, {dest_index, dest_vector}, 0);
      if (rst_n_in && redirect === 1'b1) take(1, 0, target);
      if (rst_n_in && exc_res === 1'b1) take(2, 0, 0);
      if (rst_n_in && exc_dis === 1'b1) take(3, 0, 0);
   end
   // branch, idle gap, compare in the delay slot
   task automatic br(logic [31:0] bw, logic [127:0] bv, logic tk, int gap);
      logic [63:0] spc = 64'h40_0000 + 64'(($random(seed) & 255) * 4);
      core.issue(bw, spc - 64'h4, 1'b1, a, bv);
      core.idle(gap);
      expect_note(0, '1, wd, 0);
      if (tk) expect_note(1, 0, 0, spc + {{46{bw[15]}}, bw[15:0], 2'h0});
      core.issue(enc(2, 2'h0, 7'h0, wd), spc, 1'b1, a, a);
   endtask
   task automatic test_done;
      if (errors == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge ref_clk_in);
      errors++;
      test_done();
   end
   initial begin
      repeat (4) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      for (int f = 0; f < 4; f++) for (int op = 0; op < 4; op++) begin
         w = 8 << f;
         lit = $random(seed) & (w - 1);
         s5 = 5'($random(seed));
         wd = 5'($random(seed));
         a = {$random(seed), $random(seed), $random(seed), $random(seed)};
         if (op == 3) a = fill(w, {{59{s5[4]}}, s5});
         b = (op == 2) ? a : {$random(seed), $random(seed), 64'($random(seed))};
         a = a ^ (128'h1 << ($random(seed) & 127));
         fld = (f == 0) ? {4'he, 3'(lit)} : (f == 1) ? {3'h6, 4'(lit)}
               : (f == 2) ? {2'h2, 5'(lit)} : {1'b0, 6'(lit)};
         if (op == 3) fld = {2'h0, s5};
         expect_note(0, model(op, w, a, b, lit, s5), wd, 0);
         core.issue(enc(op, 2'(f), fld, wd), 64'h100, 1'b1, a, b);
      end
      expect_note(2, 0, 0, 0);
      core.issue(enc(1, 2'h0, {4'hf, 3'(lit)}, wd), 64'h104, 1'b1, a, b);
      off = 16'($random(seed));
      for (int op = 0; op < 6; op++) begin
         expect_note(3, 0, 0, 0);
         core.issue(op < 4 ? enc(op, 2'h3, 7'h0, wd) : op == 4 ?
            {6'h11, 3'h6, 2'h0, 5'h02, off} : {6'h11, 5'h0b, 5'h02, off},
            64'h108, 1'b0, a, 128'h0);
      end
      for (int f = 0; f < 4; f++) begin
         w = 8 << f;
         b = fill(w, 64'h1);
         off = 16'($random(seed));
         br({6'h11, 3'h6, 2'(f), 5'h02, off}, b, 1'b0, f);
         b = b ^ (128'h1 << (($random(seed) & (128 / w - 1)) * w));
         br({6'h11, 3'h6, 2'(f), 5'h02, off}, b, 1'b1, f);
      end
      br({6'h11, 5'h0b, 5'h02, off}, 128'h0, 1'b1, 2);
      br({6'h11, 5'h0b, 5'h02, off}, 128'h1 << 127, 1'b0, 0);
      core.idle(4);
      cmp_kind(notes.size(), 0);
      test_done();
   end
endmodule
`default_nettype wire
